// File: hdl/urs_encoder.sv
// ULPI receive-status byte encoder with Wishbone control registers
//
// The Wishbone interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Host LS/FS line state: 00 SE0, 11 SE1, 01/10 swap K/J by speed.
// - Host HS: 00 squelch, 01 not; chirp uses diff receiver on 01/10.
// - VBUS field is registered from three comparator outputs; a-valid may come from the shared pin instead.
// - VBUS 00 below end, 01 end-valid, 10 valid-avalid, 11 above.
// - Shared pin is used as sense or fault, never both at once.
// - VBUS change sends status byte when both edge enables are set.
// - Event: 00 idle, 01 active, 11 active with error, 10 disconnect.
// - SYNC signalled by DIR with NXT, or status byte with active.
// - Receive active holds from first through last packet byte.
// - Receive error drops NXT and sends status byte with error.
// - Disconnect valid only with both pulldowns; each change sends byte when both disconnect edge enables are set.
// - Byte: line 1:0, vbus 3:2, event 5:4, id 6, alt 7.
// - Any field change sends a status byte automatically; VBUS and disconnect changes only with both of their edge enables set.
module urs_encoder
    import urs_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire urs_phy_t    phy_i,
    input  wire logic        shared_pin_i,
    input  wire logic        data_in_i,
    output urs_ulpi_t        ulpi_o
);
    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    typedef struct packed {
        urs_state_t         fsm;
        logic [7:0]         last;
        logic [7:0]         dout;
        logic               dir;
        logic               nxt;
        logic               rx_act;
        logic               rx_err;
        logic               ack;
        logic [31:0]        rdat;
        logic [CTRL_W-1:0]  ctrl;
        logic [IEN_W-1:0]   ien;
        logic               pend;
    } urs_regs_t;

    urs_regs_t  r;
    urs_regs_t  next_r;
    logic [1:0] vbus_state;
    logic [1:0] line_state;
    logic [1:0] event_code;
    logic [1:0] xs;
    logic [1:0] om;
    logic       host_mode;
    logic [7:0] cur;
    logic [7:0] masked_last;
    logic       changed;
    logic       vb_en;
    logic       hd_en;
    logic       wb_req;

    assign xs        = r.ctrl[C_XS +: 2];
    assign om        = r.ctrl[C_OM +: 2];
    assign host_mode = r.ctrl[C_DPPD] & r.ctrl[C_DMPD];
    assign vb_en     = r.ien[IE_VB_R] & r.ien[IE_VB_F];
    assign hd_en     = r.ien[IE_HD_R] & r.ien[IE_HD_F];
    assign wb_req    = wb_cyc_i & wb_stb_i & ~r.ack;

    urs_vbus_sel u_vbus (
        .clk_i                 (clk_i),
        .rst_i                 (rst_i),
        .shared_pin_i          (shared_pin_i),
        .session_end_i         (phy_i.session_end),
        .session_valid_i       (phy_i.session_valid),
        .a_device_vbus_valid_i (phy_i.a_device_vbus_valid),
        .ext_sel_i             (r.ctrl[C_EXTIND]),
        .invert_i              (r.ctrl[C_INV]),
        .pass_i                (r.ctrl[C_PASS]),
        .vbus_state_o          (vbus_state)
    );

    // --------------------------------------------------------------
    // Line state and event encoding
    // --------------------------------------------------------------
    always_comb begin
        line_state = LS_SE0;
        if (xs == XS_HS) begin
            if (om == OM_CHIRP) begin
                if (phy_i.squelch)
                    line_state = LS_SE0;
                else
                    line_state = phy_i.hs_diff ? LS_01 : LS_10;
            end else begin
                line_state = phy_i.squelch ? LS_SE0 : LS_01;
            end
        end else begin
            // Line pair to code; K/J meaning differs by speed only
            line_state = {phy_i.minus_line, phy_i.plus_line};
        end
    end

    always_comb begin
        if (host_mode && phy_i.host_disc)
            event_code = EV_DISC;
        else if (r.rx_act && r.rx_err)
            event_code = EV_ERR;
        else if (r.rx_act)
            event_code = EV_ACT;
        else
            event_code = EV_NONE;
    end

    always_comb begin
        cur = 8'h00;
        cur[LS_LSB +: 2] = line_state;
        cur[VB_LSB +: 2] = vbus_state;
        cur[EV_LSB +: 2] = event_code;
        cur[ID_BIT]      = phy_i.id_pin;
        cur[ALT_BIT]     = phy_i.alt_int;
        // Disabled fields never trigger a byte but still ride along
        masked_last = r.last;
        if (!vb_en)
            masked_last[VB_LSB +: 2] = vbus_state;
        if (!hd_en && (event_code == EV_DISC ||
                       r.last[EV_LSB +: 2] == EV_DISC))
            masked_last[EV_LSB +: 2] = event_code;
    end

    assign changed = (cur != masked_last);

    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.ack = wb_req;
        next_r.dir = 1'b0;
        next_r.nxt = 1'b0;
        if (phy_i.sync_seen)
            next_r.rx_act = 1'b1;
        if (r.rx_act && phy_i.rx_err)
            next_r.rx_err = 1'b1;
        case (r.fsm)
            URS_IDLE: begin
                if (phy_i.sync_seen) begin
                    next_r.dir = 1'b1;
                    next_r.nxt = 1'b1;
                    next_r.fsm = URS_RECV;
                end else if (changed || r.pend) begin
                    next_r.dir  = 1'b1;
                    next_r.dout = cur;
                    next_r.last = cur;
                    next_r.pend = 1'b0;
                    next_r.fsm  = URS_SEND;
                end
            end
            URS_SEND: begin
                // Back-to-back bytes keep DIR high
                if (changed) begin
                    next_r.dir  = 1'b1;
                    next_r.dout = cur;
                    next_r.last = cur;
                end else begin
                    next_r.fsm = URS_IDLE;
                end
            end
            URS_RECV: begin
                next_r.dir = 1'b1;
                if (phy_i.rx_err || r.rx_err) begin
                    next_r.nxt    = 1'b0;
                    next_r.dout   = cur;
                    next_r.last   = cur;
                    next_r.rx_act = 1'b0;
                    next_r.rx_err = 1'b0;
                    next_r.fsm    = URS_SEND;
                    next_r.dout[EV_LSB +: 2] = EV_ERR;
                    next_r.last[EV_LSB +: 2] = EV_ERR;
                    next_r.pend   = 1'b1;
                end else if (phy_i.rx_byte) begin
                    next_r.nxt  = 1'b1;
                    next_r.dout = {7'h00, data_in_i};
                    if (phy_i.rx_last) begin
                        next_r.rx_act = 1'b0;
                        next_r.fsm    = URS_SEND;
                        next_r.pend   = 1'b1;
                    end
                end else begin
                    // NXT low inside a packet is always a status byte
                    next_r.dout = cur;
                    next_r.last = cur;
                end
            end
            default: next_r.fsm = URS_IDLE;
        endcase
        // ----------------------------------------------------------
        // Register bus
        // ----------------------------------------------------------
        if (wb_req && wb_we_i) begin
            case (wb_adr_i)
                ADR_CTRL: begin
                    if (wb_sel_i[0])
                        next_r.ctrl[7:0] = wb_dat_i[7:0];
                    if (wb_sel_i[1])
                        next_r.ctrl[CTRL_W-1:8] = wb_dat_i[CTRL_W-1:8];
                end
                ADR_IEN: begin
                    if (wb_sel_i[0])
                        next_r.ien = wb_dat_i[IEN_W-1:0];
                end
                default: ;
            endcase
        end
        next_r.rdat = 32'h0000_0000;
        if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
                ADR_CTRL:   next_r.rdat = {22'h000000, r.ctrl};
                ADR_IEN:    next_r.rdat = {28'h0000000, r.ien};
                ADR_STATUS: next_r.rdat = {24'h000000, cur};
                ADR_LAST:   next_r.rdat = {24'h000000, r.last};
                default:    next_r.rdat = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r.fsm    <= URS_IDLE;
            r.last   <= 8'h00;
            r.dout   <= 8'h00;
            r.dir    <= 1'b0;
            r.nxt    <= 1'b0;
            r.rx_act <= 1'b0;
            r.rx_err <= 1'b0;
            r.ack    <= 1'b0;
            r.rdat   <= 32'h0000_0000;
            r.ctrl   <= CTRL_RST;
            r.ien    <= IEN_RST;
            r.pend   <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    assign wb_ack_o    = r.ack;
    assign wb_dat_o    = r.rdat;
    assign ulpi_o.dir  = r.dir;
    assign ulpi_o.nxt  = r.nxt;
    assign ulpi_o.data = r.dout;

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    property p_sync_dir_nxt;
        @(posedge clk_i) disable iff (rst_i)
        (r.fsm == URS_IDLE && phy_i.sync_seen) |=> (ulpi_o.dir && ulpi_o.nxt);
    endproperty
    a_sync_dir_nxt: assert property (p_sync_dir_nxt)
        else $error("sync not signalled by dir and nxt");

    property p_change_sends;
        @(posedge clk_i) disable iff (rst_i)
        (r.fsm == URS_IDLE && changed && !phy_i.sync_seen)
            |=> (ulpi_o.dir && !ulpi_o.nxt && ulpi_o.data == r.last);
    endproperty
    a_change_sends: assert property (p_change_sends)
        else $error("field change did not send status byte");

    property p_err_byte;
        @(posedge clk_i) disable iff (rst_i)
        (r.fsm == URS_RECV && phy_i.rx_err)
            |=> (!ulpi_o.nxt && ulpi_o.data[EV_LSB +: 2] == EV_ERR);
    endproperty
    a_err_byte: assert property (p_err_byte)
        else $error("receive error byte missing");

    property p_recv_dir;
        @(posedge clk_i) disable iff (rst_i)
        (r.fsm == URS_RECV) |=> ulpi_o.dir;
    endproperty
    a_recv_dir: assert property (p_recv_dir)
        else $error("dir dropped inside packet");

    property p_disc_host;
        @(posedge clk_i) disable iff (rst_i)
        (ulpi_o.dir && !ulpi_o.nxt && ulpi_o.data[EV_LSB +: 2] == EV_DISC)
            |-> $past(host_mode);
    endproperty
    a_disc_host: assert property (p_disc_host)
        else $error("disconnect reported without pulldowns");

    property p_chirp_ls;
        @(posedge clk_i) disable iff (rst_i)
        (xs == XS_HS && om == OM_CHIRP && !phy_i.squelch)
            |-> (line_state == (phy_i.hs_diff ? LS_01 : LS_10));
    endproperty
    a_chirp_ls: assert property (p_chirp_ls)
        else $error("chirp line state wrong");

    property p_fs_se0;
        @(posedge clk_i) disable iff (rst_i)
        (xs != XS_HS && !phy_i.plus_line && !phy_i.minus_line)
            |-> (line_state == LS_SE0);
    endproperty
    a_fs_se0: assert property (p_fs_se0)
        else $error("se0 not coded as 00");

    property p_vb_quiet;
        @(posedge clk_i) disable iff (rst_i)
        (!vb_en && r.fsm == URS_IDLE && $changed(vbus_state)
         && cur[7:4] == r.last[7:4] && cur[1:0] == r.last[1:0]
         && !r.pend && !phy_i.sync_seen) |=> !ulpi_o.dir;
    endproperty
    a_vb_quiet: assert property (p_vb_quiet)
        else $error("vbus byte sent while disabled");

    property p_ack_one;
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one)
        else $error("ack held two cycles");
endmodule
`default_nettype wire

// File: hdl/urs_vbus_sel.sv
// VBUS state encoder with shared sense/fault pin selection
`timescale 1ns/1ps
`default_nettype none
module urs_vbus_sel
    import urs_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       shared_pin_i,
    input  wire logic       session_end_i,
    input  wire logic       session_valid_i,
    input  wire logic       a_device_vbus_valid_i,
    input  wire logic       ext_sel_i,
    input  wire logic       invert_i,
    input  wire logic       pass_i,
    output logic [1:0]      vbus_state_o
);
    logic [1:0] state;
    logic [1:0] next_state;
    logic       avld;
    logic       fault_ok;

    // Pin serves either as fault or as the A-valid comparator, never both
    assign fault_ok = shared_pin_i ^ invert_i;
    assign avld     = ext_sel_i ? (pass_i ? fault_ok : 1'b0)
                                : a_device_vbus_valid_i;

    always_comb begin
        if (avld)
            next_state = VB_AVLD;
        else if (session_valid_i)
            next_state = VB_SESS;
        else if (session_end_i)
            next_state = VB_LOW;
        else
            next_state = VB_END;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i)
            state <= VB_LOW;
        else
            state <= next_state;
    end

    assign vbus_state_o = state;

    property p_vb_avld;
        @(posedge clk_i) disable iff (rst_i)
        avld |=> (vbus_state_o == VB_AVLD);
    endproperty
    a_vb_avld: assert property (p_vb_avld)
        else $error("vbus state not 11 with a-valid");

    property p_vb_low;
        @(posedge clk_i) disable iff (rst_i)
        (!avld && !session_valid_i && session_end_i)
            |=> (vbus_state_o == VB_LOW);
    endproperty
    a_vb_low: assert property (p_vb_low)
        else $error("vbus state not 00 below session end");
endmodule
`default_nettype wire

// File: pkg/urs_pkg.sv
// Package for the ULPI receive-status encoder: constants and carriers
package urs_pkg;

    // Status byte field positions
    localparam int LS_LSB  = 0;
    localparam int VB_LSB  = 2;
    localparam int EV_LSB  = 4;
    localparam int ID_BIT  = 6;
    localparam int ALT_BIT = 7;

    // Transceiver select and operating mode codes
    localparam logic [1:0] XS_HS    = 2'h0;
    localparam logic [1:0] XS_FS    = 2'h1;
    localparam logic [1:0] XS_LS    = 2'h2;
    localparam logic [1:0] XS_FS4   = 2'h3;
    localparam logic [1:0] OM_CHIRP = 2'h2;

    // Line state codes
    localparam logic [1:0] LS_SE0 = 2'h0;
    localparam logic [1:0] LS_01  = 2'h1;
    localparam logic [1:0] LS_10  = 2'h2;
    localparam logic [1:0] LS_SE1 = 2'h3;

    // VBUS state codes
    localparam logic [1:0] VB_LOW  = 2'h0;
    localparam logic [1:0] VB_END  = 2'h1;
    localparam logic [1:0] VB_SESS = 2'h2;
    localparam logic [1:0] VB_AVLD = 2'h3;

    // Receive event codes
    localparam logic [1:0] EV_NONE = 2'h0;
    localparam logic [1:0] EV_ACT  = 2'h1;
    localparam logic [1:0] EV_ERR  = 2'h3;
    localparam logic [1:0] EV_DISC = 2'h2;

    // Register map (Wishbone byte addresses)
    localparam logic [3:0] ADR_CTRL   = 4'h0;
    localparam logic [3:0] ADR_IEN    = 4'h4;
    localparam logic [3:0] ADR_STATUS = 4'h8;
    localparam logic [3:0] ADR_LAST   = 4'hc;

    // Control register bits
    localparam int C_XS     = 0;
    localparam int C_TERM   = 2;
    localparam int C_OM     = 3;
    localparam int C_DPPD   = 5;
    localparam int C_DMPD   = 6;
    localparam int C_EXTIND = 7;
    localparam int C_INV    = 8;
    localparam int C_PASS   = 9;
    localparam int CTRL_W   = 10;

    // Interrupt enable bits: vbus rise/fall, disconnect rise/fall
    localparam int IE_VB_R = 0;
    localparam int IE_VB_F = 1;
    localparam int IE_HD_R = 2;
    localparam int IE_HD_F = 3;
    localparam int IEN_W   = 4;

    localparam logic [CTRL_W-1:0] CTRL_RST = 10'h001;
    localparam logic [IEN_W-1:0]  IEN_RST  = 4'h0;

    typedef enum logic [1:0] {
        URS_IDLE = 2'b00,
        URS_SEND = 2'b01,
        URS_RECV = 2'b11
    } urs_state_t;

    // Analog/receiver inputs
    typedef struct packed {
        logic plus_line;
        logic minus_line;
        logic squelch;
        logic hs_diff;
        logic session_end;
        logic session_valid;
        logic a_device_vbus_valid;
        logic id_pin;
        logic alt_int;
        logic sync_seen;
        logic rx_byte;
        logic rx_last;
        logic rx_err;
        logic host_disc;
    } urs_phy_t;

    // Link-side bus outputs
    typedef struct packed {
        logic       dir;
        logic       nxt;
        logic [7:0] data;
    } urs_ulpi_t;

endpackage

// File: test/ulpi_rx_status_encoder_test.sv
// Self-checking bench for the receive-status encoder
`timescale 1ns/1ps
`default_nettype none
module ulpi_rx_status_encoder_test
    import urs_pkg::*;
;
    logic        clk_i;
    logic        rst_i;
    logic [3:0]  adr;
    logic [31:0] wdat;
    logic [3:0]  sel;
    logic        we;
    logic        cyc;
    logic        stb;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    urs_phy_t    phy;
    logic        pin;
    logic        din;
    urs_ulpi_t   ulpi_o;
    logic [7:0]  last;
    int          cnt;
    logic        active;
    logic        drop;
    int          errors;
    int          tests_run;
    int          cycles;
    int          quiet;
    logic [31:0] q;
    // Ctrl, plus, minus, squelch, diff, expected line state
    localparam logic [15:0] LT [10] = '{16'h0161, 16'h0152, 16'h0173,
        16'h0140, 16'h0192, 16'h0001, 16'h0008, 16'h0405, 16'h0402,
        16'h0140};
    // Session end, session valid, a-valid, expected vbus state
    localparam logic [4:0] VT [4] = '{5'h01, 5'h1a, 5'h1f, 5'h10};

    urs_encoder dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .phy_i(phy), .shared_pin_i(pin), .data_in_i(din),
        .ulpi_o(ulpi_o));
    urs_link_model link_u (.clk_i(clk_i), .rst_i(rst_i), .ulpi_i(ulpi_o),
        .last_o(last), .count_o(cnt), .active_o(active), .drop_o(drop));

    task automatic chk(input string n, input logic [31:0] s, e);
        tests_run++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask

    task automatic wb(input logic [3:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        adr <= a;
        we <= w;
        wdat <= d;
        sel <= 4'hf;
        cyc <= 1'b1;
        stb <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n == 50) errors++;
        r = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb(a, 1'b1, d, r);
    endtask

    // Bounded wait for the next status byte, then let things settle
    task automatic st(input logic [7:0] m, input logic [7:0] e);
        int n;
        int c;
        logic [31:0] r;
        c = cnt;
        n = 0;
        while (cnt == c && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        repeat (3) @(posedge clk_i);
        wb(ADR_STATUS, 1'b0, 32'h0, r);
        chk("status", {24'h0, r[7:0] & m}, {24'h0, e & m});
        chk("link", {24'h0, last & m}, {24'h0, e & m});
    endtask

    task print_verdict;
        if (errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            print_verdict();
        end
    end

    initial begin
        rst_i = 1'b1;
        {adr, wdat, sel, we, cyc, stb, pin, din} = '0;
        phy = '0;
        phy.session_end = 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(ADR_CTRL, 1'b0, 32'h0, q);
        chk("ctrl", q, {22'h0, CTRL_RST});
        wb(ADR_IEN, 1'b0, 32'h0, q);
        chk("ien", q, {28'h0, IEN_RST});
        wr(4'h2, 32'hffff_ffff);
        wb(4'h2, 1'b0, 32'h0, q);
        chk("unmapped", q, 32'h0);
        foreach (LT[i]) begin
            wr(ADR_CTRL, {22'h0, LT[i][15:6]});
            {phy.plus_line, phy.minus_line} <= LT[i][5:4];
            {phy.squelch, phy.hs_diff} <= LT[i][3:2];
            st(8'h03, {6'h0, LT[i][1:0]});
        end
        // VBUS change with its enables off must stay silent
        quiet = cnt;
        phy.session_end <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk("vbus quiet", cnt, quiet);
        phy.session_end <= 1'b1;
        repeat (3) @(posedge clk_i);
        wr(ADR_IEN, 32'h3);
        foreach (VT[i]) begin
            {phy.session_end, phy.session_valid} <= VT[i][4:3];
            phy.a_device_vbus_valid <= VT[i][2];
            st(8'h0c, {4'h0, VT[i][1:0], 2'h0});
        end
        // Comparator a-valid must be ignored while the pin is the fault
        wr(ADR_CTRL, 32'h285);
        phy.a_device_vbus_valid <= 1'b1;
        st(8'h0c, 8'h00);
        pin <= 1'b1;
        st(8'h0c, 8'h0c);
        wr(ADR_CTRL, 32'h385);
        st(8'h0c, 8'h00);
        wr(ADR_CTRL, 32'h005);
        phy.a_device_vbus_valid <= 1'b0;
        pin <= 1'b0;
        wr(ADR_IEN, 32'hf);
        phy.host_disc <= 1'b1;
        st(8'h30, 8'h00);
        wr(ADR_CTRL, 32'h065);
        st(8'h30, 8'h20);
        phy.host_disc <= 1'b0;
        st(8'h30, 8'h00);
        {phy.id_pin, phy.alt_int} <= 2'b11;
        st(8'hc0, 8'hc0);
        phy.sync_seen <= 1'b1;
        @(posedge clk_i);
        phy.sync_seen <= 1'b0;
        phy.rx_byte <= 1'b1;
        din <= 1'b1;
        repeat (2) @(posedge clk_i);
        phy.rx_last <= 1'b1;
        @(posedge clk_i);
        chk("active", active, 1'b1);
        chk("rx dir", ulpi_o.dir, 1'b1);
        chk("rx data", ulpi_o.data, 8'h01);
        {phy.rx_byte, phy.rx_last} <= 2'b00;
        st(8'h30, 8'h00);
        chk("inactive", active, 1'b0);
        phy.sync_seen <= 1'b1;
        @(posedge clk_i);
        phy.sync_seen <= 1'b0;
        phy.rx_byte <= 1'b1;
        @(posedge clk_i);
        phy.rx_err <= 1'b1;
        @(posedge clk_i);
        {phy.rx_byte, phy.rx_err} <= 2'b00;
        @(posedge clk_i);
        chk("nxt", ulpi_o.nxt, 1'b0);
        chk("err event", ulpi_o.data[EV_LSB +: 2], EV_ERR);
        repeat (4) @(posedge clk_i);
        chk("drop", drop, 1'b1);
        print_verdict();
    end
endmodule
`default_nettype wire

// File: test/urs_link_model.sv
// Link controller model that watches the ULPI side of the encoder
`timescale 1ns/1ps
`default_nettype none
module urs_link_model
    import urs_pkg::*;
(
    input  wire logic      clk_i,
    input  wire logic      rst_i,
    input  wire urs_ulpi_t ulpi_i,
    output logic [7:0]     last_o,
    output int             count_o,
    output logic           active_o,
    output logic           drop_o
);
    // Always ready: the link never stalls a status byte
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last_o <= 8'h00;
            count_o <= 0;
            active_o <= 1'b0;
            drop_o <= 1'b0;
        end else if (!ulpi_i.dir) begin
            active_o <= 1'b0;
        end else if (ulpi_i.nxt) begin
            active_o <= 1'b1;
        end else begin
            last_o <= ulpi_i.data;
            count_o <= count_o + 1;
            active_o <= ulpi_i.data[4];
            if (ulpi_i.data[5:4] == EV_ERR) begin
                drop_o <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire
